// file: btpa_cbw_dec.sv
// command wrapper parser: length, direction and pin test match
`timescale 1ns/1ps
module btpa_cbw_dec (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // wrapper byte stream, byte 0 first
  input wire logic cbw_valid,
  input wire logic [7:0] cbw_byte,
  // designator taken from configuration data
  input wire logic [7:0] cfg_designator,
  // decoded command
  output logic cmd_pulse,
  output logic cmd_desig_ok,
  output logic cmd_sub_ok,
  output logic cmd_dir_in,
  output logic [31:0] cmd_len
);
  import btpa_pkg::*;

  typedef struct packed {
    logic [4:0] idx;
    logic pulse;
    logic desig_ok;
    logic sub_ok;
    logic dir_in;
    logic [31:0] len;
  } btpa_dec_s_t;

  btpa_dec_s_t q, d;

  ////////////////////////////////////////////////////////////////////////
  // byte counter and field capture
  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (cbw_valid) begin
      d.idx = (q.idx == CBW_LAST_IDX) ? 5'h00 : 5'(q.idx + 5'h01);
      if (q.idx[4:2] == CBW_LEN_WORD) begin
        d.len[q.idx[1:0]*8 +: 8] = cbw_byte;
      end
      if (q.idx == CBW_FLAGS_IDX) begin
        d.dir_in = cbw_byte[CBW_DIR_BIT];
      end
      if (q.idx == CBW_CB0_IDX) begin
        d.desig_ok = (cbw_byte == cfg_designator);
      end
      if (q.idx == CBW_CB1_IDX) begin
        d.sub_ok = (cbw_byte == SUBCMD_PIN_TEST);
      end
      if (q.idx == CBW_LAST_IDX) begin
        d.pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cmd_pulse = q.pulse;
  assign cmd_desig_ok = q.desig_ok;
  assign cmd_sub_ok = q.sub_ok;
  assign cmd_dir_in = q.dir_in;
  assign cmd_len = q.len;

  a_sub_match: assert property (@(posedge mclk) disable iff (!rst_n)
    cbw_valid && q.idx == CBW_CB1_IDX
      |=> q.sub_ok == ($past(cbw_byte) == SUBCMD_PIN_TEST))
    else $error("sub-command match flag wrong");
endmodule // btpa_cbw_dec

// file: btpa_host.sv
// host model issuing pin test wrappers and data phases
`timescale 1ns/1ps
module btpa_host (
  // clock
  input wire logic mclk,
  // wrapper stream
  output logic cbw_valid,
  output logic [7:0] cbw_byte,
  // load data
  output logic dat_in_valid,
  output logic [7:0] dat_in_byte,
  input wire logic dat_in_ready,
  // read data
  input wire logic dat_out_valid,
  input wire logic [7:0] dat_out_byte,
  output logic dat_out_ready
);
  // idle levels at time zero
  initial begin
    cbw_valid = 1'b0;
    cbw_byte = 8'h00;
    dat_in_valid = 1'b0;
    dat_in_byte = 8'h00;
    dat_out_ready = 1'b0;
  end
  ////////////////////////////////////////
  // one wrapper, byte 0 first, command block bytes 2..15 zero
  task automatic send_cbw(input logic [7:0] desig, input logic [7:0] sub,
      input logic [31:0] len, input logic dir_in);
    logic [247:0] w;
    w = '0;
    w[64+:32] = len;
    w[96+:8] = {dir_in, 7'h00};
    w[112+:8] = 8'h10;
    w[120+:8] = desig;
    w[128+:8] = sub;
    for (int i = 0; i < 31; i++) begin
      @(posedge mclk);
      cbw_valid <= 1'b1;
      cbw_byte <= w[8*i+:8];
    end
    @(posedge mclk);
    cbw_valid <= 1'b0;
    cbw_byte <= ~w[240+:8]; // released line never shows the old byte
  endtask
  // load bytes, each held until ready is seen at an edge
  task automatic load_data(input logic [55:0] pkt, input int n);
    logic r;
    for (int i = 0; i < n; i++) begin
      dat_in_valid <= 1'b1;
      dat_in_byte <= pkt[8*i+:8];
      r = 1'b0;
      while (!r) begin
        @(negedge mclk);
        r = dat_in_ready;
        @(posedge mclk);
      end
    end
    dat_in_valid <= 1'b0;
    dat_in_byte <= ~pkt[8*(n-1)+:8];
  endtask
  // read phase of eight bytes
  task automatic read_data(output logic [63:0] d);
    logic r;
    logic [7:0] v;
    dat_out_ready <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = 1'b0;
      while (!r) begin
        @(negedge mclk);
        r = dat_out_valid;
        v = dat_out_byte;
        @(posedge mclk);
      end
      d[8*i+:8] = v;
    end
    dat_out_ready <= 1'b0;
  endtask
endmodule // btpa_host

// file: btpa_pkg.sv
// constants and types shared by the board test pin access block
package btpa_pkg;
  // command wrapper byte positions
  localparam logic [4:0] CBW_LAST_IDX = 5'h1e;
  localparam logic [2:0] CBW_LEN_WORD = 3'h2; // bytes 8..11
  localparam logic [4:0] CBW_FLAGS_IDX = 5'h0c;
  localparam logic [4:0] CBW_CB0_IDX = 5'h0f;
  localparam logic [4:0] CBW_CB1_IDX = 5'h10;
  localparam int CBW_DIR_BIT = 7;
  localparam logic [7:0] SUBCMD_PIN_TEST = 8'h27;
  // data phase sizes
  localparam logic [31:0] LOAD_BYTES = 32'h0000_0007;
  localparam logic [31:0] READ_BYTES = 32'h0000_0008;
  // load packet field positions
  localparam int LD_DA_LSB = 1;
  localparam int LD_CS_LSB = 4;
  localparam int LD_RST_BIT = 7;
  localparam int LD_WR_BIT = 0;
  localparam int LD_RD_BIT = 1;
  localparam int LD_DMACK_BIT = 2;
  localparam int LD_DDEN_BIT = 7;
  localparam int LD_DD_LO = 2;
  localparam int LD_DD_HI = 3;
  // read packet field positions
  localparam int RD_INTRQ_BIT = 0;
  localparam int RD_VBUS_BIT = 6;
  localparam int RD_RST_BIT = 7;
  localparam int RD_IORDY_BIT = 3;
  localparam int RD_DMARQ_BIT = 4;
  localparam int RD_PEN_BIT = 5;
  localparam int RD_DDEN_BIT = 7;
  // configuration memory
  localparam int EE_BYTES = 256;
  localparam int EE_AW = $clog2(EE_BYTES);
  localparam logic [2:0] EE_DEV_ADDR = 3'h4; // straps a2..a0 = 1,0,0
  // pin values while nothing drives them
  localparam logic [1:0] CS_N_IDLE = 2'h3;
  // command sequencer states
  typedef enum logic [1:0] {
    BTPA_IDLE = 2'b00,
    BTPA_LOAD = 2'b01,
    BTPA_READ = 2'b10
  } btpa_state_t;
endpackage

// file: btpa_snap.sv
// one-instant snapshot of sampled pins and read byte select
`timescale 1ns/1ps
module btpa_snap (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // capture strobe
  input wire logic take,
  // sampled pins
  input wire logic intrq,
  input wire logic bus_power_good,
  input wire logic reset_echo,
  input wire logic iordy,
  input wire logic dmarq,
  input wire logic drive_port_enable_in,
  input wire logic dd_driven,
  input wire logic [15:0] dd_in,
  // byte select
  input wire logic [2:0] sel,
  input wire logic sel_ok,
  output logic [7:0] rd_byte
);
  import btpa_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] snap;
  } btpa_snap_s_t;

  btpa_snap_s_t q, d;

  ////////////////////////////////////////////////////////////////////////
  // capture every pin at the same edge, reserved bits zero
  always_comb begin
    d = q;
    if (take) begin
      d.snap = '0;
      d.snap[0][RD_INTRQ_BIT] = intrq;
      d.snap[0][RD_VBUS_BIT] = bus_power_good;
      d.snap[0][RD_RST_BIT] = reset_echo;
      d.snap[1][RD_IORDY_BIT] = iordy;
      d.snap[1][RD_DMARQ_BIT] = dmarq;
      d.snap[1][RD_PEN_BIT] = drive_port_enable_in;
      d.snap[1][RD_DDEN_BIT] = dd_driven;
      d.snap[2] = dd_in[7:0];
      d.snap[3] = dd_in[15:8];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_byte = sel_ok ? q.snap[sel] : 8'h00;

  a_snap_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !take |=> $stable(q.snap))
    else $error("snapshot changed without capture");
endmodule // btpa_snap

// file: btpa_top.sv
// board test pin access: pin test command, pin drive and pin sampling
// Function
// - sub-command byte must be 0x27
// - designator compared against configured value
// - transfer length from wrapper bytes 8-11
// - direction bit picks load or read
// - load enters test mode, pins from packet
// - load moves exactly seven bytes
// - only hard reset leaves test mode
// - load bytes 0,1 map address, selects, strobes
// - byte 1 bit 7 enables data bus
// - read returns one instant snapshot
// - read data phase is eight bytes
// - read packet bit mapping of inputs
// - inputs sampled any time in test mode
// - normal mode serves descriptors from memory
// - configuration memory is 256 bytes
// - memory device address straps 0x04
// - bad or missing signature gives board test
// - board test keeps storage port inactive
`timescale 1ns/1ps
module btpa_top #(
  parameter int LEN_W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // power-up configuration result
  input wire logic cfg_done,
  input wire logic cfg_sig_ok,
  input wire logic [7:0] cfg_designator,
  // command wrapper stream
  input wire logic cbw_valid,
  input wire logic [7:0] cbw_byte,
  // load data, host to device
  input wire logic dat_in_valid,
  input wire logic [7:0] dat_in_byte,
  output logic dat_in_ready,
  // read data, device to host
  output logic dat_out_valid,
  output logic [7:0] dat_out_byte,
  input wire logic dat_out_ready,
  // command end
  output logic cmd_done,
  output logic cmd_len_err,
  // mode status
  output logic mfg_mode,
  output logic test_mode,
  output logic storage_active,
  // functional storage port control
  input wire logic [2:0] fn_da,
  input wire logic [1:0] fn_cs_n,
  input wire logic fn_reset_n,
  input wire logic fn_wr_n,
  input wire logic fn_rd_n,
  input wire logic fn_dmack_n,
  input wire logic [15:0] fn_dd,
  input wire logic fn_dd_oe_n,
  // storage port pins
  output logic [2:0] da,
  output logic [1:0] cs_n,
  output logic drive_reset_output,
  output logic write_strobe_output,
  output logic read_strobe_output,
  output logic dma_ack_output,
  output logic [15:0] dd_out,
  output logic dd_oe_n,
  input wire logic [15:0] dd_in,
  input wire logic intrq,
  input wire logic iordy,
  input wire logic dmarq,
  input wire logic bus_power_good,
  input wire logic drive_port_enable_in,
  // descriptor reads from configuration memory
  input wire logic desc_req,
  input wire logic [btpa_pkg::EE_AW-1:0] desc_addr,
  output logic desc_valid,
  output logic [7:0] desc_data,
  output logic ee_req,
  output logic [btpa_pkg::EE_AW-1:0] ee_addr,
  output logic [2:0] ee_dev_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data
);
  import btpa_pkg::*;

  typedef struct packed {
    btpa_state_t st;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] cnt;
    logic [6:0][7:0] pkt;
    logic test_mode;
    logic mfg_mode;
    logic cfg_seen;
    logic done;
    logic len_err;
    logic [2:0] da;
    logic [1:0] cs_n;
    logic rst_o;
    logic wr_n;
    logic rd_n;
    logic dmack_n;
    logic [15:0] dd;
    logic dd_oe_n;
    logic ee_req;
    logic [EE_AW-1:0] ee_addr;
    logic desc_valid;
    logic [7:0] desc_data;
  } btpa_top_s_t;

  btpa_top_s_t q, d;

  logic dec_pulse;
  logic dec_desig_ok;
  logic dec_sub_ok;
  logic dec_dir_in;
  logic [31:0] dec_len;
  logic snap_take;
  logic [7:0] snap_byte;
  logic hit;
  logic last_beat;

  ////////////////////////////////////////////////////////////////////////
  // wrapper parser and pin snapshot
  btpa_cbw_dec u_dec (
    .mclk(mclk),
    .rst_n(rst_n),
    .cbw_valid(cbw_valid),
    .cbw_byte(cbw_byte),
    .cfg_designator(cfg_designator),
    .cmd_pulse(dec_pulse),
    .cmd_desig_ok(dec_desig_ok),
    .cmd_sub_ok(dec_sub_ok),
    .cmd_dir_in(dec_dir_in),
    .cmd_len(dec_len)
  );

  btpa_snap u_snap (
    .mclk(mclk),
    .rst_n(rst_n),
    .take(snap_take),
    .intrq(intrq),
    .bus_power_good(bus_power_good),
    .reset_echo(q.rst_o),
    .iordy(iordy),
    .dmarq(dmarq),
    .drive_port_enable_in(drive_port_enable_in),
    .dd_driven(!q.dd_oe_n),
    .dd_in(dd_in),
    .sel(q.cnt[2:0]),
    .sel_ok(q.cnt < LEN_W'(READ_BYTES)),
    .rd_byte(snap_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // command acceptance terms
  assign hit = dec_pulse && dec_desig_ok && dec_sub_ok;
  assign snap_take = hit && q.mfg_mode && dec_dir_in && q.st == BTPA_IDLE;
  assign last_beat = (LEN_W'(q.cnt + 1'b1) == q.len);

  ////////////////////////////////////////////////////////////////////////
  // sequencer, pin drive and descriptor path
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.ee_req = 1'b0;
    d.desc_valid = 1'b0;
    // power-up memory check picks the mode once
    if (cfg_done && !q.cfg_seen) begin
      d.cfg_seen = 1'b1;
      d.mfg_mode = !cfg_sig_ok;
    end
    unique case (q.st)
      BTPA_IDLE: begin
        // a mismatched wrapper falls through untouched
        if (hit && q.mfg_mode) begin
          d.len = LEN_W'(dec_len);
          d.cnt = '0;
          d.len_err = 1'b0;
          if (dec_len == 32'h0) begin
            d.done = 1'b1;
          end else if (dec_dir_in) begin
            d.st = BTPA_READ;
            d.len_err = (dec_len != READ_BYTES);
          end else begin
            d.st = BTPA_LOAD;
            d.len_err = (dec_len != LOAD_BYTES);
          end
        end
      end
      BTPA_LOAD: begin
        if (dat_in_valid) begin
          // a wrong-length load must not disturb the held packet
          if (q.cnt < LEN_W'(LOAD_BYTES) && !q.len_err) begin
            d.pkt[q.cnt[2:0]] = dat_in_byte;
          end
          d.cnt = LEN_W'(q.cnt + 1'b1);
          if (last_beat) begin
            d.st = BTPA_IDLE;
            d.done = 1'b1;
            // only a seven-byte load enters test mode, then the packet drives the pins
            if (!q.len_err) begin
              d.test_mode = 1'b1;
            end else begin
              d.pkt = q.pkt;
            end
          end
        end
      end
      BTPA_READ: begin
        if (dat_out_ready) begin
          d.cnt = LEN_W'(q.cnt + 1'b1);
          if (last_beat) begin
            d.st = BTPA_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: begin
        d.st = BTPA_IDLE;
      end
    endcase
    // pin drive: packet in test mode, idle in board test or before the memory check, else functional
    if (q.test_mode) begin
      d.da = q.pkt[0][LD_DA_LSB +: 3];
      d.cs_n = q.pkt[0][LD_CS_LSB +: 2];
      d.rst_o = q.pkt[0][LD_RST_BIT];
      d.wr_n = q.pkt[1][LD_WR_BIT];
      d.rd_n = q.pkt[1][LD_RD_BIT];
      d.dmack_n = q.pkt[1][LD_DMACK_BIT];
      d.dd = {q.pkt[LD_DD_HI], q.pkt[LD_DD_LO]};
      d.dd_oe_n = !q.pkt[1][LD_DDEN_BIT];
    end else if (q.mfg_mode || !q.cfg_seen) begin
      d.da = '0;
      d.cs_n = CS_N_IDLE;
      d.rst_o = 1'b1;
      d.wr_n = 1'b1;
      d.rd_n = 1'b1;
      d.dmack_n = 1'b1;
      d.dd = '0;
      d.dd_oe_n = 1'b1;
    end else begin
      d.da = fn_da;
      d.cs_n = fn_cs_n;
      d.rst_o = fn_reset_n;
      d.wr_n = fn_wr_n;
      d.rd_n = fn_rd_n;
      d.dmack_n = fn_dmack_n;
      d.dd = fn_dd;
      d.dd_oe_n = fn_dd_oe_n;
    end
    // descriptor bytes come from the configuration memory in normal mode
    if (desc_req && q.cfg_seen && !q.mfg_mode) begin
      d.ee_req = 1'b1;
      d.ee_addr = desc_addr;
    end
    if (ee_ack) begin
      d.desc_valid = 1'b1;
      d.desc_data = ee_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= BTPA_IDLE;
      q.cs_n <= CS_N_IDLE;
      q.rst_o <= 1'b1;
      q.wr_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.dmack_n <= 1'b1;
      q.dd_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign dat_in_ready = (q.st == BTPA_LOAD);
  assign dat_out_valid = (q.st == BTPA_READ);
  assign dat_out_byte = snap_byte;
  assign cmd_done = q.done;
  assign cmd_len_err = q.len_err;
  assign mfg_mode = q.mfg_mode;
  assign test_mode = q.test_mode;
  assign storage_active = q.cfg_seen && !q.mfg_mode;
  assign da = q.da;
  assign cs_n = q.cs_n;
  assign drive_reset_output = q.rst_o;
  assign write_strobe_output = q.wr_n;
  assign read_strobe_output = q.rd_n;
  assign dma_ack_output = q.dmack_n;
  assign dd_out = q.dd;
  assign dd_oe_n = q.dd_oe_n;
  assign desc_valid = q.desc_valid;
  assign desc_data = q.desc_data;
  assign ee_req = q.ee_req;
  assign ee_addr = q.ee_addr;
  assign ee_dev_addr = EE_DEV_ADDR;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_test_sticky: assert property (q.test_mode |=> q.test_mode)
    else $error("test mode left without reset");

  a_load_seven: assert property ($rose(q.test_mode) |->
    $past(q.len) == 7 && $past(q.cnt) == 6)
    else $error("test mode entered without seven-byte load");

  a_load_dir: assert property (q.st == BTPA_IDLE ##1 q.st == BTPA_LOAD
    |-> $past(!dec_dir_in && dec_sub_ok && dec_desig_ok))
    else $error("load started without matching out command");

  a_read_dir: assert property (q.st == BTPA_IDLE ##1 q.st == BTPA_READ
    |-> $past(dec_dir_in && dec_sub_ok && dec_desig_ok))
    else $error("read started without matching in command");

  a_pin_map: assert property (q.test_mode |=>
    da == $past(q.pkt[0][3:1]) && cs_n == $past(q.pkt[0][5:4])
    && write_strobe_output == $past(q.pkt[1][0]))
    else $error("test packet not mapped to pins");

  a_dd_enable: assert property (q.test_mode |=>
    dd_oe_n == !$past(q.pkt[1][7]) && dd_out == $past({q.pkt[3], q.pkt[2]}))
    else $error("data bus drive does not follow packet");

  a_no_alter: assert property (
    dec_pulse && !(dec_sub_ok && dec_desig_ok) && q.st == BTPA_IDLE
    |=> q.st == BTPA_IDLE && $stable(q.pkt) ##1 $stable(q.pkt))
    else $error("mismatched command altered pin packet");

  a_board_mode: assert property (
    cfg_done && !q.cfg_seen && !cfg_sig_ok |=> mfg_mode && !storage_active)
    else $error("bad signature did not give board test mode");

  a_read_len: assert property (q.st == BTPA_READ && dat_out_ready
    && last_beat |=> cmd_done && q.st == BTPA_IDLE)
    else $error("read phase did not end at wrapper length");

  c_load: cover property ($rose(q.test_mode));
  c_read: cover property (q.st == BTPA_READ && dat_out_ready && last_beat
    && q.len == 8);
  c_ignored: cover property (dec_pulse && !dec_sub_ok && q.mfg_mode);
  c_desc: cover property (desc_valid);
endmodule // btpa_top

// file: btpa_top_tb.sv
// self-checking bench of the board test pin access block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module btpa_top_tb;
  import btpa_pkg::*;
  localparam logic [7:0] DESIG = 8'h5e;
  localparam logic [55:0] PKT1 = 56'hffffffc35a851a;
  localparam logic [55:0] PKT2 = 56'h000000c35a029a;
  logic mclk = 1'b0;
  logic rst_n, cfg_done, cfg_sig_ok, desc_req, ee_ack, ee_req, desc_valid;
  logic cbw_valid, dat_in_valid, dat_in_ready, dat_out_valid, dat_out_ready;
  logic [7:0] cbw_byte, dat_in_byte, dat_out_byte, desc_data, ee_data;
  logic [EE_AW-1:0] desc_addr, ee_addr;
  logic cmd_done, cmd_len_err, mfg_mode, test_mode, storage_active;
  logic [2:0] fn_da, da, ee_dev_addr;
  logic [1:0] fn_cs_n, cs_n;
  logic fn_reset_n, fn_wr_n, fn_rd_n, fn_dmack_n, fn_dd_oe_n, dd_oe_n;
  logic [15:0] fn_dd, dd_out, dd_in;
  logic drive_reset_output, write_strobe_output, read_strobe_output;
  logic dma_ack_output, intrq, iordy, dmarq, bus_power_good;
  logic drive_port_enable_in;
  int num_errors = 0, checks = 0, n_done = 0, cyc = 0;
  btpa_top #(.LEN_W(32)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .cfg_done(cfg_done),
    .cfg_sig_ok(cfg_sig_ok), .cfg_designator(DESIG),
    .cbw_valid(cbw_valid), .cbw_byte(cbw_byte),
    .dat_in_valid(dat_in_valid), .dat_in_byte(dat_in_byte),
    .dat_in_ready(dat_in_ready), .dat_out_valid(dat_out_valid),
    .dat_out_byte(dat_out_byte), .dat_out_ready(dat_out_ready),
    .cmd_done(cmd_done), .cmd_len_err(cmd_len_err), .mfg_mode(mfg_mode),
    .test_mode(test_mode), .storage_active(storage_active),
    .fn_da(fn_da), .fn_cs_n(fn_cs_n), .fn_reset_n(fn_reset_n),
    .fn_wr_n(fn_wr_n), .fn_rd_n(fn_rd_n), .fn_dmack_n(fn_dmack_n),
    .fn_dd(fn_dd), .fn_dd_oe_n(fn_dd_oe_n), .da(da), .cs_n(cs_n),
    .drive_reset_output(drive_reset_output),
    .write_strobe_output(write_strobe_output),
    .read_strobe_output(read_strobe_output),
    .dma_ack_output(dma_ack_output), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
    .dd_in(dd_in), .intrq(intrq), .iordy(iordy), .dmarq(dmarq),
    .bus_power_good(bus_power_good),
    .drive_port_enable_in(drive_port_enable_in), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_valid(desc_valid), .desc_data(desc_data),
    .ee_req(ee_req), .ee_addr(ee_addr), .ee_dev_addr(ee_dev_addr),
    .ee_ack(ee_ack), .ee_data(ee_data));
  btpa_host i_host (
    .mclk(mclk), .cbw_valid(cbw_valid), .cbw_byte(cbw_byte),
    .dat_in_valid(dat_in_valid), .dat_in_byte(dat_in_byte),
    .dat_in_ready(dat_in_ready), .dat_out_valid(dat_out_valid),
    .dat_out_byte(dat_out_byte), .dat_out_ready(dat_out_ready));
  ////////////////////////////////////////
  // clock
  always #5 mclk = ~mclk;
  // done pulse count and hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cmd_done === 1'b1) n_done <= n_done + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hard reset, idle pins while held
  task automatic do_reset();
    rst_n <= 1'b0;
    @(negedge mclk);
    `CHK(cs_n, CS_N_IDLE)
    `CHK(dd_oe_n, 1'b1)
    `CHK(test_mode, 1'b0)
    `CHK(ee_dev_addr, EE_DEV_ADDR)
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask
  // power-up memory check result
  task automatic boot(input logic ok);
    cfg_sig_ok <= ok;
    cfg_done <= 1'b1;
    @(posedge mclk);
    cfg_done <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK(mfg_mode, ~ok)
    `CHK(storage_active, ok)
    @(posedge mclk);
  endtask
  // normal mode: pins, descriptor fetch, pin command ignored
  task automatic t_normal();
    boot(1'b1);
    fn_da <= 3'h5;
    fn_dd <= 16'ha5c3;
    fn_dd_oe_n <= 1'b0;
    desc_req <= 1'b1;
    desc_addr <= 8'h12;
    @(posedge mclk);
    desc_req <= 1'b0;
    @(negedge mclk);
    `CHK(ee_req, 1'b1)
    `CHK(ee_addr, 8'h12)
    @(posedge mclk);
    ee_ack <= 1'b1;
    ee_data <= 8'h3c;
    @(posedge mclk);
    ee_ack <= 1'b0;
    @(negedge mclk);
    `CHK(desc_valid, 1'b1)
    `CHK(desc_data, 8'h3c)
    `CHK(da, 3'h5)
    `CHK(dd_out, 16'ha5c3)
    @(posedge mclk);
    i_host.send_cbw(DESIG, SUBCMD_PIN_TEST, READ_BYTES, 1'b1);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(dat_out_valid, 1'b0)
    @(posedge mclk);
  endtask
  // read phase; inputs flip after the snapshot edge
  task automatic chk_read(input logic rst_e, input logic dden_e);
    logic [63:0] d;
    logic [7:0] e0, e1;
    logic [15:0] dd;
    int nd;
    e0 = {rst_e, bus_power_good, 5'h00, intrq};
    e1 = {dden_e, 1'b0, drive_port_enable_in, dmarq, iordy, 3'h0};
    dd = dd_in;
    nd = n_done;
    i_host.send_cbw(DESIG, SUBCMD_PIN_TEST, READ_BYTES, 1'b1);
    repeat (2) @(posedge mclk);
    intrq <= ~intrq;
    dd_in <= ~dd_in;
    i_host.read_data(d);
    repeat (2) @(posedge mclk);
    `CHK(d[7:0] & 8'hc1, e0)
    `CHK(d[15:8] & 8'hb8, e1)
    `CHK(d[31:16], dd)
    `CHK(n_done, nd + 1)
    `CHK(cmd_len_err, 1'b0)
  endtask
  // wrong designator, then wrong sub-command
  task automatic t_mismatch(input logic [2:0] ea, input logic tm);
    i_host.send_cbw(DESIG ^ 8'h01, SUBCMD_PIN_TEST, LOAD_BYTES, 1'b0);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(dat_in_ready, 1'b0)
    @(posedge mclk);
    i_host.send_cbw(DESIG, 8'h26, LOAD_BYTES, 1'b0);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(dat_in_ready, 1'b0)
    `CHK(da, ea)
    `CHK(test_mode, tm)
    @(posedge mclk);
  endtask
  // load of given length, then settle
  task automatic do_load(input logic [55:0] p, input int n);
    i_host.send_cbw(DESIG, SUBCMD_PIN_TEST, n, 1'b0);
    i_host.load_data(p, n);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  // short load is refused, full load takes the pins
  task automatic t_load();
    do_load(PKT1, 6);
    `CHK(cmd_len_err, 1'b1)
    `CHK(test_mode, 1'b0)
    `CHK(cs_n, CS_N_IDLE)
    fn_da <= 3'h2;
    @(posedge mclk);
    do_load(PKT1, 7);
    `CHK(test_mode, 1'b1)
    `CHK(cmd_len_err, 1'b0)
    `CHK(da, 3'h5)
    `CHK(cs_n, 2'h1)
    `CHK(drive_reset_output, 1'b0)
    `CHK({write_strobe_output, read_strobe_output}, 2'h2)
    `CHK(dma_ack_output, 1'b1)
    `CHK(dd_oe_n, 1'b0)
    `CHK(dd_out, 16'hc35a)
    @(posedge mclk);
    chk_read(1'b0, 1'b1);
    // short load in test mode leaves the driven pins alone
    do_load(PKT2, 6);
    `CHK(cmd_len_err, 1'b1)
    `CHK(dd_oe_n, 1'b0)
    `CHK({write_strobe_output, read_strobe_output}, 2'h2)
    @(posedge mclk);
    do_load(PKT2, 7);
    `CHK(dd_oe_n, 1'b1)
    `CHK({write_strobe_output, read_strobe_output}, 2'h1)
    @(posedge mclk);
    chk_read(1'b1, 1'b0);
  endtask
  // only a hard reset leaves test mode
  task automatic t_hard();
    `CHK(test_mode, 1'b1)
    do_reset();
    boot(1'b0);
    `CHK(test_mode, 1'b0)
    `CHK(cs_n, CS_N_IDLE)
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, cfg_done, cfg_sig_ok, desc_req, ee_ack, fn_dd_oe_n} = 6'h01;
    {desc_addr, ee_data, fn_da, fn_cs_n, fn_dd} = '0;
    {fn_reset_n, fn_wr_n, fn_rd_n, fn_dmack_n} = 4'hf;
    {intrq, iordy, dmarq, bus_power_good, drive_port_enable_in} = 5'h0d;
    dd_in = 16'h1234;
    do_reset();
    t_normal();
    do_reset();
    boot(1'b0);
    chk_read(1'b1, 1'b0);
    t_mismatch(3'h0, 1'b0);
    t_load();
    t_mismatch(3'h5, 1'b1);
    t_hard();
    print_verdict();
  end
endmodule // btpa_top_tb
